// ===== design/dcsw_defines.vh
// Purpose: constants for the drive command/status word block
// Assumes: plain register port, 16-bit data in low bits
// Notes: offsets are word indices on the plain port
`ifndef DCSW_DEFINES_VH
`define DCSW_DEFINES_VH

`define DCSW_ADDR_W 4
`define DCSW_OFS_CMD 4'h0
`define DCSW_OFS_STATUS 4'h1
`define DCSW_CMD_RESET 16'h0000
`define DCSW_STATUS_RESET 16'h0000

// command word bit positions
`define DCSW_CMD_RUN 0
`define DCSW_CMD_COAST_N 1
`define DCSW_CMD_QUICK_N 2
`define DCSW_CMD_ENABLE 3
`define DCSW_CMD_FAULT_CLR 7

// status word bit positions
`define DCSW_ST_SW_ON_EN 0
`define DCSW_ST_SWITCHED_ON 1
`define DCSW_ST_RUNNING 2
`define DCSW_ST_FAULT 3
`define DCSW_ST_COAST_N 4
`define DCSW_ST_QUICK_N 5
`define DCSW_ST_SW_ON_DIS 6
`define DCSW_ST_REMOTE 9
`define DCSW_ST_SETPOINT 10
`define DCSW_ST_LIMIT 11

// sequencer state code for start-disabled
`define DCSW_SEQ_START_DISABLED 3'h0

`endif

// ===== design/dcsw_top.v
// Purpose: drive command word interpreter and status word builder
// Assumes: all inputs are on core_clk, from the register port, local controls, sequencer and ramp logic
// Notes: command applied to sequencer only in remote mode, whatever remote_comms_sel
//
// Behaviour
// (R1) command word applied only in remote mode
// (R2) bit 0 drives forward run only
// (R3) coast stop input is bit1 AND local
// (R4) fast stop input is bit2 AND local
// (R5) enable is bit3 AND local enable
// (R6) bit 7 rising edge clears fault
// (R7) master writes fixed unimplemented bit values
// (R8) master writes 047F run, 047E stop
// (R9) 16-bit status, unsupported bits read zero
// (R10) status bit 0 is switch-on-enable
// (R11) status bit 1 is switched-on
// (R12) status bit 2 is running
// (R13) status bit 3 is tripped
// (R14) status bit 4 coast stop, mode dependent
// (R15) status bit 5 fast stop, mode dependent
// (R16) status bit 6 set in start-disabled
// (R17) status bit 9 remote and select set
// (R18) status bit 10 when not ramping
// (R19) status bit 11 on torque/current limit
// (R20) trip leaves only on reset rising edge
// (R21) sequencer state codes zero to seven
// (R22) command word resets to zero
//
// Local design decisions: the placing of the registers and strobed register access.
`include "dcsw_defines.vh"

module dcsw_top (
  input wire core_clk,
  input wire resetn,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire remote_mode,
  input wire remote_comms_sel,
  input wire local_forward_run,
  input wire local_reverse_run,
  input wire local_latched_stop,
  input wire local_coast_stop_n,
  input wire local_fast_stop_n,
  input wire local_drive_enable,
  input wire local_fault_clear,
  input wire [2:0] seq_state,
  input wire seq_switch_on_enable,
  input wire seq_switched_on,
  input wire seq_running,
  input wire seq_tripped,
  input wire ramp_active,
  input wire vector_mode,
  input wire torque_limit,
  input wire current_limit,
  output reg forward_run,
  output reg reverse_run,
  output reg latched_stop,
  output reg coast_off_command_n,
  output reg quick_off_command_n,
  output reg drive_enable,
  output reg remote_fault_clear,
  output reg fault_clear_pulse,
  output reg [15:0] status_word
);

  ////////////////////////////////////////////////////////////////////////
  reg [15:0] cmd_reg;
  reg fclr_prev_reg;
  wire fclr_src;
  wire coast_n_next;
  wire quick_n_next;
  reg [15:0] status_next;

  // command word store; unimplemented bits kept as written
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= `DCSW_CMD_RESET; // R22
    end else if (reg_wr && reg_addr == `DCSW_OFS_CMD) begin
      cmd_reg <= reg_wdata;
    end
  end

  // read data one cycle after strobe; unmapped reads zero
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `DCSW_OFS_CMD: reg_rdata <= cmd_reg;
        `DCSW_OFS_STATUS: reg_rdata <= status_word;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // local stop inputs always take part, so a local stop wins in any mode
  assign coast_n_next = remote_mode ? (cmd_reg[`DCSW_CMD_COAST_N] & local_coast_stop_n)
                                    : local_coast_stop_n; // R3 R1
  assign quick_n_next = remote_mode ? (cmd_reg[`DCSW_CMD_QUICK_N] & local_fast_stop_n)
                                    : local_fast_stop_n; // R4 R1
  assign fclr_src = remote_mode ? cmd_reg[`DCSW_CMD_FAULT_CLR] : local_fault_clear; // R6 R1

  // sequencer inputs, registered so every output leaves a flip-flop
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      forward_run <= 1'b0;
      reverse_run <= 1'b0;
      latched_stop <= 1'b0;
      coast_off_command_n <= 1'b0;
      quick_off_command_n <= 1'b0;
      drive_enable <= 1'b0;
      remote_fault_clear <= 1'b0;
      fclr_prev_reg <= 1'b0;
      fault_clear_pulse <= 1'b0;
    end else begin
      if (remote_mode) begin
        forward_run <= cmd_reg[`DCSW_CMD_RUN]; // R2 R1
        reverse_run <= 1'b0; // R2
        latched_stop <= 1'b0; // R2
        drive_enable <= cmd_reg[`DCSW_CMD_ENABLE] & local_drive_enable; // R5
      end else begin
        forward_run <= local_forward_run;
        reverse_run <= local_reverse_run;
        latched_stop <= local_latched_stop;
        drive_enable <= local_drive_enable;
      end
      coast_off_command_n <= coast_n_next;
      quick_off_command_n <= quick_n_next;
      remote_fault_clear <= fclr_src; // R6
      fclr_prev_reg <= fclr_src;
      // a 0 to 1 step gives a clear pulse only while seq_tripped is set
      fault_clear_pulse <= fclr_src & ~fclr_prev_reg & seq_tripped; // R6 R20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status word assembly; bits 7, 8, 12..15 stay zero
  always @* begin
    status_next = 16'h0000; // R9
    status_next[`DCSW_ST_SW_ON_EN] = seq_switch_on_enable; // R10
    status_next[`DCSW_ST_SWITCHED_ON] = seq_switched_on; // R11
    status_next[`DCSW_ST_RUNNING] = seq_running; // R12
    status_next[`DCSW_ST_FAULT] = seq_tripped; // R13
    status_next[`DCSW_ST_COAST_N] = remote_mode ? cmd_reg[`DCSW_CMD_COAST_N]
                                                : local_coast_stop_n; // R14
    status_next[`DCSW_ST_QUICK_N] = remote_mode ? cmd_reg[`DCSW_CMD_QUICK_N]
                                                : local_fast_stop_n; // R15
    status_next[`DCSW_ST_SW_ON_DIS] = (seq_state == `DCSW_SEQ_START_DISABLED); // R16 R21
    status_next[`DCSW_ST_REMOTE] = remote_mode & remote_comms_sel; // R17
    status_next[`DCSW_ST_SETPOINT] = ~ramp_active; // R18
    status_next[`DCSW_ST_LIMIT] = vector_mode ? torque_limit : current_limit; // R19
  end

  // registered status; one cycle behind its sources
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_word <= `DCSW_STATUS_RESET;
    end else begin
      status_word <= status_next;
    end
  end

endmodule // dcsw_top

// ===== testbench/dcsw_top_properties.sv
// Purpose: port checker for dcsw_top
// Assumes: one clock, resetn active low
// Notes: outputs lag their sources by one edge
module dcsw_chk (
  input wire core_clk,
  input wire resetn,
  input wire remote_mode,
  input wire remote_comms_sel,
  input wire local_coast_stop_n,
  input wire local_fast_stop_n,
  input wire seq_tripped,
  input wire ramp_active,
  input wire reverse_run,
  input wire latched_stop,
  input wire coast_off_command_n,
  input wire quick_off_command_n,
  input wire [15:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // no reverse or latched stop in remote; a local stop must win whatever the master wrote
  property p_rev; remote_mode |=> !reverse_run && !latched_stop; endproperty
  a_rev: assert property (p_rev) else $error("reverse in remote");
  property p_cst; !local_coast_stop_n |=> !coast_off_command_n; endproperty
  a_cst: assert property (p_cst) else $error("coast lost");
  property p_qst; !local_fast_stop_n |=> !quick_off_command_n; endproperty
  a_qst: assert property (p_qst) else $error("quick lost");
  // reserved status bits 7, 8, 12..15 always read zero
  property p_rsv; (status_word & 16'hF180) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  // status checks start only once reset was seen released, so reset values never compare
  property p_trp; resetn |=> status_word[3] == $past(seq_tripped); endproperty
  a_trp: assert property (p_trp) else $error("fault bit");
  property p_loc; resetn && !remote_mode |=> status_word[5:4] == $past({local_fast_stop_n,
    local_coast_stop_n}); endproperty
  a_loc: assert property (p_loc) else $error("local stops");
  property p_rem; resetn |=> status_word[9] == $past(remote_mode & remote_comms_sel); endproperty
  a_rem: assert property (p_rem) else $error("remote bit");
  property p_rmp; resetn |=> status_word[10] == !$past(ramp_active); endproperty
  a_rmp: assert property (p_rmp) else $error("ramp bit");
endmodule // dcsw_chk
bind dcsw_top dcsw_chk u_chk (.*);

// ===== testbench/dcsw_plc.sv
// Purpose: remote fieldbus master model
// Assumes: read data one cycle after the strobe
// Notes: write data inverted once released
module dcsw_plc (
  input wire core_clk,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] RUN_WORD = 16'h047F;
  localparam logic [15:0] STOP_WORD = 16'h047E;
  initial {reg_addr, reg_wdata, reg_rd, reg_wr} = 22'h000000;
  ////////////////////////////////////////////////////////////
  // stale data would look valid, so it is inverted
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    {reg_wdata, reg_wr} <= {~d, 1'b0};
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // dcsw_plc

// ===== testbench/test_drive_command_status_word.sv
// Purpose: self-checking bench for dcsw_top
// Assumes: dcsw_plc stands in for the master
// Notes: expected status built from inputs and cmd
module test_drive_command_status_word;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, reg_wr, reg_rd, remote_mode, remote_comms_sel, local_forward_run;
  logic local_reverse_run, local_latched_stop, local_coast_stop_n, local_fast_stop_n;
  logic local_drive_enable, local_fault_clear, seq_switch_on_enable, seq_switched_on;
  logic seq_running, seq_tripped, ramp_active, vector_mode, torque_limit, current_limit;
  logic forward_run, reverse_run, latched_stop, coast_off_command_n, quick_off_command_n;
  logic drive_enable, remote_fault_clear, fault_clear_pulse;
  logic [2:0] seq_state;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, status_word, cmd, rv;
  int error_cnt, checks_done, cyc, pulses;
  dcsw_top u_dut (.*);
  dcsw_plc u_plc (.*);
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ceiling far above the run, and pulse count
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    pulses <= pulses + fault_clear_pulse;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic st(input logic [15:0] o);
    u_plc.rd(4'h1, rv);
    chk("status", {4'h0, vector_mode ? torque_limit : current_limit, !ramp_active,
      remote_mode & remote_comms_sel, 2'b00, seq_state == 3'h0,
      remote_mode ? cmd[2:1] : {local_fast_stop_n, local_coast_stop_n}, seq_tripped,
      seq_running, seq_switched_on, seq_switch_on_enable}, rv);
    chk("outs", o, {forward_run, reverse_run, latched_stop, coast_off_command_n,
      quick_off_command_n, drive_enable});
  endtask
  initial begin
    {remote_mode, remote_comms_sel, local_forward_run, local_reverse_run, local_latched_stop,
      local_fault_clear, seq_tripped, seq_running, resetn, cmd} = '0;
    {local_coast_stop_n, local_fast_stop_n, local_drive_enable} = 3'b111;
    {seq_switch_on_enable, seq_switched_on, ramp_active, vector_mode, seq_state} = '0;
    {torque_limit, current_limit} = 2'b00;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    u_plc.rd(4'h0, rv);
    chk("cmd", 16'h0000, rv);
    u_plc.rd(4'hF, rv);
    chk("unmapped", 16'h0000, rv);
    $display("reset test done");
    remote_mode <= 1'b1;
    cmd = u_plc.RUN_WORD;
    u_plc.wr(4'h0, cmd);
    st(16'h0027);
    {local_coast_stop_n, local_fast_stop_n, local_drive_enable} <= 3'b000;
    st(16'h0020);
    {local_coast_stop_n, local_fast_stop_n, local_drive_enable, seq_tripped} <= 4'hF;
    cmd = u_plc.STOP_WORD | 16'h0080;
    u_plc.wr(4'h5, cmd);
    u_plc.wr(4'h0, cmd);
    st(16'h0007);
    chk("clear", 16'h0003, {remote_fault_clear, pulses == 1});
    seq_tripped <= 1'b0;
    u_plc.wr(4'h0, u_plc.STOP_WORD);
    u_plc.wr(4'h0, cmd);
    st(16'h0007);
    chk("no clear", 16'h0001, {pulses == 1});
    $display("command test done");
    local_forward_run <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      {seq_state, seq_switch_on_enable, seq_switched_on, seq_running, seq_tripped} <=
        {i[2:0], i[3:0]};
      {remote_mode, remote_comms_sel, ramp_active, vector_mode, torque_limit, current_limit,
        local_coast_stop_n, local_fast_stop_n} <= {i[3:0], i[3:0]};
      st({10'h000, !i[3], 2'b00, i[1], i[0], 1'b1});
    end
    $display("status test done");
    final_report();
  end
endmodule // test_drive_command_status_word
